// File: shared/pll_seq_defs.vh
// constants for the pll startup sequencer
`ifndef PLL_SEQ_DEFS_VH
`define PLL_SEQ_DEFS_VH
// apb register offsets
`define REG_CTRL 12'h000
`define REG_CFG 12'h004
`define REG_STATUS 12'h008
`define REG_IRQ_STAT 12'h00c
`define REG_IRQ_MASK 12'h010
`define REG_TIMEOUT 12'h014
// ctrl fields
`define CTRL_START 0
// cfg fields
`define CFG_SRC_LO 0
`define CFG_SRC_HI 1
`define CFG_NDIV_LO 8
`define CFG_NDIV_HI 14
`define CFG_PDIV_LO 16
`define CFG_PDIV_HI 19
`define CFG_TGT_LO 24
`define CFG_TGT_HI 30
// reference source codes
`define SRC_CRYSTAL 2'h0
`define SRC_DIRECT 2'h1
`define SRC_INTERNAL 2'h2
// divider preset for 10 mhz
`define PRE_NDIV 7'h13
`define PRE_PDIV 4'h1
`define PRE_ODIV 7'h14
`define RST_CFG 32'h0400_1302
// band code
`define BAND_BASE 1'b0
`define BAND_NORMAL 1'b1
// error codes
`define ERR_NONE 3'h0
`define ERR_OSC 3'h1
`define ERR_LOCK 3'h2
`define ERR_SRC 3'h3
// timing
`define TIMEOUT_RST 32'h0001_0000
`define SETTLE_CYC 8'h10
`define STEP_CYC 8'h20
// irq bits
`define IRQ_DONE 0
`define IRQ_ERR 1
`endif

// File: design/pll_startup_reconfig.v
// apb-controlled sequencer for the pll switch from base to normal setup
`timescale 1ns/1ps
`default_nettype none
`include "pll_seq_defs.vh"
module pll_startup_reconfig (
   // clock and reset
   input wire SYS_CLK_I,
   input wire RST_I,
   // apb slave
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire [11:0] PADDR_I,
   input wire [31:0] PWDATA_I,
   output reg [31:0] PRDATA_O,
   output reg PREADY_O,
   output reg PSLVERR_O,
   // device status
   input wire PLL_LOCK_I,
   input wire OSC_STABLE_I,
   // device controls
   output reg OSC_ENABLE_O,
   output reg VCO_BYPASS_O,
   output reg VCO_DISCONNECT_O,
   output reg SYSCLK_FROM_VCO_O,
   output reg OUTDIV_FROM_PLL_O,
   output reg [1:0] REF_SELECT_O,
   output reg VCO_BAND_O,
   output reg [6:0] INPUT_DIVIDER_O,
   output reg [3:0] FEEDBACK_DIVIDER_O,
   output reg [6:0] OUTPUT_DIVIDER_O,
   output reg EMERGENCY_ARM_O,
   // interrupt
   output reg IRQ_O
);
   localparam S_IDLE = 4'h0;
   localparam S_PREP = 4'h1;
   localparam S_BYPASS = 4'h2;
   localparam S_PRESET = 4'h3;
   localparam S_DISC = 4'h4;
   localparam S_OSCWAIT = 4'h5;
   localparam S_PLLPATH = 4'h6;
   localparam S_REFSW = 4'h7;
   localparam S_RECONN = 4'h8;
   localparam S_LOCKWAIT = 4'h9;
   localparam S_ARM = 4'ha;
   localparam S_RAMP = 4'hb;
   localparam S_DONE = 4'hc;
   localparam S_ERR = 4'hd;

   reg [3:0] state;
   reg [31:0] cfg;
   reg [31:0] timeout;
   reg [1:0] irq_stat;
   reg [1:0] irq_mask;
   reg [2:0] err_code;
   reg [31:0] wait_cnt;
   reg [7:0] settle;
   reg busy;
   reg done_ev;
   reg err_ev;
   wire [1:0] src;
   wire [6:0] target_div;
   wire apb_wr;
   wire apb_rd;
   wire start;

   assign src = cfg[`CFG_SRC_HI:`CFG_SRC_LO];
   assign target_div = cfg[`CFG_TGT_HI:`CFG_TGT_LO];
   // apb access phase; slave acts in the first access cycle and answers in the second, one wait state
   assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I & ~PREADY_O;
   assign apb_rd = PSEL_I & PENABLE_I & ~PWRITE_I & ~PREADY_O;
   assign start = apb_wr & (PADDR_I == `REG_CTRL) & PWDATA_I[`CTRL_START];

   // decode used by both read and write paths
   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `REG_CTRL) | (a == `REG_CFG) | (a == `REG_STATUS) |
                  (a == `REG_IRQ_STAT) | (a == `REG_IRQ_MASK) | (a == `REG_TIMEOUT);
      end
   endfunction

   // apb handshake and read mux
   always @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= 32'h0000_0000;
      end else begin
         PREADY_O <= PSEL_I & PENABLE_I & ~PREADY_O;
         PSLVERR_O <= PSEL_I & PENABLE_I & ~PREADY_O & ~mapped(PADDR_I);
         if (apb_rd) begin
            case (PADDR_I)
               `REG_CFG: PRDATA_O <= cfg;
               `REG_STATUS: PRDATA_O <= {16'h0000, 1'b0, err_code, state,
                  6'h00, OSC_STABLE_I, PLL_LOCK_I};
               `REG_IRQ_STAT: PRDATA_O <= {30'h0, irq_stat};
               `REG_IRQ_MASK: PRDATA_O <= {30'h0, irq_mask};
               `REG_TIMEOUT: PRDATA_O <= timeout;
               default: PRDATA_O <= {31'h0, busy};
            endcase
         end else begin
            PRDATA_O <= 32'h0000_0000;
         end
      end
   end

   // config, mask and sticky status; a new event beats a write-one clear
   always @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cfg <= `RST_CFG;
         timeout <= `TIMEOUT_RST;
         irq_mask <= 2'h0;
         irq_stat <= 2'h0;
         IRQ_O <= 1'b0;
      end else begin
         // config is frozen while a sequence runs so the presets stay coherent
         if (apb_wr & (PADDR_I == `REG_CFG) & ~busy)
            cfg <= PWDATA_I;
         if (apb_wr & (PADDR_I == `REG_TIMEOUT))
            timeout <= PWDATA_I;
         if (apb_wr & (PADDR_I == `REG_IRQ_MASK))
            irq_mask <= PWDATA_I[1:0];
         if (apb_wr & (PADDR_I == `REG_IRQ_STAT))
            irq_stat <= (irq_stat & ~PWDATA_I[1:0]) | {err_ev, done_ev};
         else
            irq_stat <= irq_stat | {err_ev, done_ev};
         IRQ_O <= |(irq_stat & irq_mask);
      end
   end

   // sequencer
   always @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state <= S_IDLE;
         busy <= 1'b0;
         err_code <= `ERR_NONE;
         wait_cnt <= 32'h0;
         settle <= 8'h00;
         done_ev <= 1'b0;
         err_ev <= 1'b0;
         OSC_ENABLE_O <= 1'b0;
         VCO_BYPASS_O <= 1'b0;
         VCO_DISCONNECT_O <= 1'b0;
         SYSCLK_FROM_VCO_O <= 1'b0;
         OUTDIV_FROM_PLL_O <= 1'b1;
         REF_SELECT_O <= `SRC_INTERNAL;
         VCO_BAND_O <= `BAND_BASE;
         INPUT_DIVIDER_O <= `PRE_NDIV;
         FEEDBACK_DIVIDER_O <= `PRE_PDIV;
         OUTPUT_DIVIDER_O <= `PRE_ODIV;
         EMERGENCY_ARM_O <= 1'b0;
      end else begin
         done_ev <= 1'b0;
         err_ev <= 1'b0;
         if (settle != 8'h00)
            settle <= settle - 8'h01;
         case (state)
            S_IDLE: begin
               if (start) begin
                  busy <= 1'b1;
                  err_code <= `ERR_NONE;
                  EMERGENCY_ARM_O <= 1'b0;
                  if (src == 2'h3) begin
                     // only three reference choices exist
                     err_code <= `ERR_SRC;
                     state <= S_ERR;
                  end else
                     state <= S_PREP;
               end
            end
            S_PREP: begin
               // crystal started first so it settles during the rest
               if (src == `SRC_CRYSTAL)
                  OSC_ENABLE_O <= 1'b1;
               state <= S_BYPASS;
            end
            S_BYPASS: begin
               VCO_BYPASS_O <= 1'b1;
               OUTDIV_FROM_PLL_O <= 1'b0;
               settle <= `SETTLE_CYC;
               state <= S_PRESET;
            end
            S_PRESET: begin
               if (settle == 8'h00) begin
                  INPUT_DIVIDER_O <= `PRE_NDIV;
                  FEEDBACK_DIVIDER_O <= `PRE_PDIV;
                  OUTPUT_DIVIDER_O <= `PRE_ODIV;
                  // a rerun may leave an external reference; bypass hides the move
                  if (src == `SRC_INTERNAL)
                     REF_SELECT_O <= `SRC_INTERNAL;
                  VCO_BAND_O <= `BAND_NORMAL;
                  settle <= `SETTLE_CYC;
                  wait_cnt <= 32'h0;
                  // internal reference has no switch or disconnect
                  state <= (src == `SRC_INTERNAL) ? S_PLLPATH : S_DISC;
               end
            end
            S_DISC: begin
               if (settle == 8'h00) begin
                  SYSCLK_FROM_VCO_O <= 1'b1;
                  VCO_DISCONNECT_O <= 1'b1;
                  settle <= `SETTLE_CYC;
                  state <= (src == `SRC_CRYSTAL) ? S_OSCWAIT : S_PLLPATH;
               end
            end
            S_OSCWAIT: begin
               // stability checked as late as possible
               if (OSC_STABLE_I)
                  state <= S_PLLPATH;
               else if (wait_cnt >= timeout) begin
                  err_code <= `ERR_OSC;
                  state <= S_ERR;
               end else
                  wait_cnt <= wait_cnt + 32'h1;
            end
            S_PLLPATH: begin
               if (settle == 8'h00) begin
                  OUTDIV_FROM_PLL_O <= 1'b1;
                  VCO_BYPASS_O <= 1'b0;
                  SYSCLK_FROM_VCO_O <= 1'b0;
                  settle <= `SETTLE_CYC;
                  wait_cnt <= 32'h0;
                  state <= (src == `SRC_INTERNAL) ? S_LOCKWAIT : S_REFSW;
               end
            end
            S_REFSW: begin
               if (settle == 8'h00) begin
                  REF_SELECT_O <= src;
                  settle <= `SETTLE_CYC;
                  state <= S_RECONN;
               end
            end
            S_RECONN: begin
               if (settle == 8'h00) begin
                  VCO_DISCONNECT_O <= 1'b0;
                  wait_cnt <= 32'h0;
                  state <= S_LOCKWAIT;
               end
            end
            S_LOCKWAIT: begin
               if (PLL_LOCK_I)
                  state <= S_ARM;
               else if (wait_cnt >= timeout) begin
                  err_code <= `ERR_LOCK;
                  state <= S_ERR;
               end else
                  wait_cnt <= wait_cnt + 32'h1;
            end
            S_ARM: begin
               // no fault handling for the internal reference
               EMERGENCY_ARM_O <= (src != `SRC_INTERNAL);
               settle <= `STEP_CYC;
               state <= S_RAMP;
            end
            S_RAMP: begin
               // one divider step per interval avoids a frequency jump
               if (OUTPUT_DIVIDER_O <= target_div)
                  state <= S_DONE;
               else if (settle == 8'h00) begin
                  OUTPUT_DIVIDER_O <= OUTPUT_DIVIDER_O - 7'h01;
                  settle <= `STEP_CYC;
               end
            end
            S_DONE: begin
               busy <= 1'b0;
               done_ev <= 1'b1;
               state <= S_IDLE;
            end
            S_ERR: begin
               busy <= 1'b0;
               err_ev <= 1'b1;
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: verification/pll_seq_checker_assertions.sv
// port-level assertions for the pll startup sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pll_seq_defs.vh"
module pll_seq_checker (
   // clock, reset and device status
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic PLL_LOCK_I,
   input wire logic OSC_STABLE_I,
   // device controls
   input wire logic OSC_ENABLE_O,
   input wire logic VCO_BYPASS_O,
   input wire logic VCO_DISCONNECT_O,
   input wire logic SYSCLK_FROM_VCO_O,
   input wire logic OUTDIV_FROM_PLL_O,
   input wire logic [1:0] REF_SELECT_O,
   input wire logic VCO_BAND_O,
   input wire logic [6:0] OUTPUT_DIVIDER_O,
   input wire logic EMERGENCY_ARM_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);
   arm_after_lock_a: assert property ($rose(EMERGENCY_ARM_O) |-> PLL_LOCK_I)
      else $error("arm raised without lock");
   band_in_bypass_a: assert property ($rose(VCO_BAND_O) |-> VCO_BYPASS_O)
      else $error("band changed outside bypass");
   div_preset_a: assert property ($changed(OUTPUT_DIVIDER_O)
      && OUTPUT_DIVIDER_O == `PRE_ODIV |-> VCO_BYPASS_O)
      else $error("divider preset outside bypass");
   div_step_a: assert property ($changed(OUTPUT_DIVIDER_O) && !VCO_BYPASS_O
      |-> OUTPUT_DIVIDER_O == $past(OUTPUT_DIVIDER_O) - 7'h01 && PLL_LOCK_I)
      else $error("divider not lowered by one step");
   disc_on_vco_a: assert property ($rose(VCO_DISCONNECT_O) |-> SYSCLK_FROM_VCO_O)
      else $error("disconnect while not on vco clock");
   ref_while_disc_a: assert property ($changed(REF_SELECT_O) && REF_SELECT_O != `SRC_INTERNAL
      |-> VCO_DISCONNECT_O && OUTDIV_FROM_PLL_O) else $error("reference moved while connected");
   release_path_a: assert property ($fell(VCO_DISCONNECT_O)
      |-> OUTDIV_FROM_PLL_O && !VCO_BYPASS_O && !SYSCLK_FROM_VCO_O) else $error("bad release");
   osc_ready_a: assert property ($rose(OUTDIV_FROM_PLL_O) |-> !VCO_BYPASS_O
      && (!OSC_ENABLE_O || OSC_STABLE_I)) else $error("pll path before oscillator stable");
endmodule
`default_nettype wire

// File: verification/pll_device_model.sv
// behavioural clock unit answering the sequencer's controls
`timescale 1ns/1ps
`default_nettype none
module pll_device_model #(parameter int LOCK_CYC = 40, parameter int OSC_CYC = 60) (
   input wire logic clk,
   input wire logic osc_dead,
   input wire logic osc_en,
   input wire logic bypass,
   input wire logic disc,
   output logic lock,
   output logic osc_ok
);
   int lc = 0;
   int oc = 0;
   // lock builds only while the vco is fed and not bypassed; a dead crystal never settles
   always @(posedge clk) begin
      lc <= (bypass || disc) ? 0 : lc + 1;
      oc <= (osc_en && !osc_dead) ? oc + 1 : 0;
   end
   assign lock = lc >= LOCK_CYC;
   assign osc_ok = oc >= OSC_CYC;
endmodule
`default_nettype wire

// File: verification/tb_pll_startup_reconfig.sv
// self-checking bench for the pll startup sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pll_seq_defs.vh"
module tb_pll_startup_reconfig;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
   note_t notes[$];
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, dead = 0;
   logic [11:0] pa = 0;
   logic [31:0] pwd = 0, rd;
   wire [31:0] prdata;
   wire pready, pslverr, lock, osc_ok, osc_en, byp, disc, svco, k2p, band, arm, irq;
   wire [1:0] ref_sel;
   wire [6:0] ndiv, kdiv;
   wire [3:0] pdiv;
   int err_total = 0, comparisons = 0;
   initial forever #4 clk = ~clk;
   pll_startup_reconfig DUT (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .PLL_LOCK_I(lock), .OSC_STABLE_I(osc_ok), .OSC_ENABLE_O(osc_en),
      .VCO_BYPASS_O(byp), .VCO_DISCONNECT_O(disc), .SYSCLK_FROM_VCO_O(svco),
      .OUTDIV_FROM_PLL_O(k2p), .REF_SELECT_O(ref_sel), .VCO_BAND_O(band), .INPUT_DIVIDER_O(ndiv),
      .FEEDBACK_DIVIDER_O(pdiv), .OUTPUT_DIVIDER_O(kdiv), .EMERGENCY_ARM_O(arm), .IRQ_O(irq));
   pll_device_model dev (.clk(clk), .osc_dead(dead), .osc_en(osc_en), .bypass(byp),
      .disc(disc), .lock(lock), .osc_ok(osc_ok));
   task automatic cmp(string nm, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // each answer is paired with the oldest note left by the driver
   always @(posedge clk) if (pready === 1'b1 && notes.size() > 0) begin
      note_t n;
      n = notes.pop_front();
      cmp("prdata", n.d & n.m, prdata & n.m);
      cmp("pslverr", {31'h0, n.e}, {31'h0, pslverr});
   end
   // one apb transfer, held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         input logic [31:0] ed, input logic [31:0] m, input logic ee);
      int n;
      notes.push_back('{ed, m, ee});
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) err_total++;
      rd = prdata;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
   endtask
   task automatic rdx(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 32'h0, e, m, 1'b0);
   endtask
   // start one sequence, poll busy, then check and clear the sticky flags
   task automatic run(input logic [1:0] src, input logic [6:0] tgt, input logic [31:0] ie,
         input logic [2:0] ee, input logic il);
      int k;
      wr(`REG_CFG, {1'b0, tgt, 22'h0, src});
      wr(`REG_CTRL, 32'h1);
      k = 0;
      do begin
         rdx(`REG_CTRL, 32'h0, 32'h0);
         k++;
      end while (rd[0] !== 1'b0 && k < 2000);
      rdx(`REG_IRQ_STAT, ie, 32'h3);
      rdx(`REG_STATUS, {17'h0, ee, 12'h0}, 32'h7000);
      cmp("irq", {31'h0, il}, {31'h0, irq});
      wr(`REG_IRQ_STAT, 32'h3);
      rdx(`REG_IRQ_STAT, 32'h0, 32'h3);
      cmp("irq clear", 32'h0, {31'h0, irq});
      $display("sequence with source %0d finished", src);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // hang guard, well beyond the few thousand cycles the tests need
   initial begin
      #400000;
      err_total++;
      summarize();
   end
   initial begin
      int t;
      logic [6:0] tgt;
      void'($urandom(99));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rdx(`REG_CFG, `RST_CFG, 32'hffffffff);
      rdx(`REG_TIMEOUT, `TIMEOUT_RST, 32'hffffffff);
      cmp("ref reset", 32'h2, {30'h0, ref_sel});
      apb(1'b0, 12'hffc, 32'h0, 32'h0, 32'h0, 1'b1);
      $display("reset and map test finished");
      wr(`REG_TIMEOUT, 32'h200);
      wr(`REG_IRQ_MASK, 32'h3);
      for (t = 0; t < 3; t++) begin
         tgt = 7'($urandom_range(19, 1));
         run(2'(t), tgt, 32'h1, 3'h0, 1'b1);
         cmp("divider target", {25'h0, tgt}, {25'h0, kdiv});
         cmp("presets", {21'h0, `PRE_NDIV, `PRE_PDIV}, {21'h0, ndiv, pdiv});
         if (t == 0) cmp("osc enable", 32'h1, {31'h0, osc_en});
         cmp("ref", t, {30'h0, ref_sel});
         cmp("arm", {31'h0, t != 2}, {31'h0, arm});
         cmp("band", 32'h1, {31'h0, band});
         cmp("path", 32'h1, {28'h0, byp, disc, svco, k2p});
      end
      dead <= 1'b1;
      wr(`REG_IRQ_MASK, 32'h1);
      run(`SRC_CRYSTAL, 7'h5, 32'h2, `ERR_OSC, 1'b0);
      run(2'h3, 7'h5, 32'h2, `ERR_SRC, 1'b0);
      summarize();
   end
endmodule
bind pll_startup_reconfig pll_seq_checker chk (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I),
   .PLL_LOCK_I(PLL_LOCK_I), .OSC_STABLE_I(OSC_STABLE_I), .OSC_ENABLE_O(OSC_ENABLE_O),
   .VCO_BYPASS_O(VCO_BYPASS_O), .VCO_DISCONNECT_O(VCO_DISCONNECT_O),
   .SYSCLK_FROM_VCO_O(SYSCLK_FROM_VCO_O), .OUTDIV_FROM_PLL_O(OUTDIV_FROM_PLL_O),
   .REF_SELECT_O(REF_SELECT_O), .VCO_BAND_O(VCO_BAND_O), .OUTPUT_DIVIDER_O(OUTPUT_DIVIDER_O),
   .EMERGENCY_ARM_O(EMERGENCY_ARM_O));
`default_nettype wire
